// ===== shared/pms_defs.svh
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PMS_CLK_MHZ       50
`define PMS_SWRST_NS      320
`define PMS_SWRST_CYC     ((`PMS_SWRST_NS * `PMS_CLK_MHZ + 999) / 1000)
`define PMS_IRQ_GAP_NS    100
`define PMS_IRQ_GAP_CYC   ((`PMS_IRQ_GAP_NS * `PMS_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// frame layout
// ----------------------------------------
`define PMS_PRE_LEN       32
`define PMS_OP_RD         2'b10
`define PMS_OP_WR         2'b01

// ----------------------------------------
// management register numbers, bits, defaults
// ----------------------------------------
`define PMS_REG_CTRL      5'h00
`define PMS_REG_STAT      5'h01
`define PMS_REG_ID1       5'h02
`define PMS_REG_ID2       5'h03
`define PMS_REG_ADV       5'h04
`define PMS_REG_LPA       5'h05
`define PMS_REG_EXP       5'h06
`define PMS_REG_ACK       5'h15
`define PMS_REG_SPEC      5'h18
`define PMS_CTRL_RST      15
`define PMS_CTRL_SPEED    13
`define PMS_CTRL_ANRST    9
`define PMS_CTRL_DUPLEX   8
`define PMS_SPEC_POL      13
`define PMS_CTRL_DEF      16'h3100
`define PMS_CTRL_WMASK    16'h7F80
`define PMS_STAT_DEF      16'h7809
`define PMS_ADV_DEF       16'h01E1
`define PMS_ADV_WMASK     16'h3FFF

// ----------------------------------------
// wishbone map
// ----------------------------------------
`define PMS_WB_STATUS     4'h0
`define PMS_WB_MASK       4'h4
`define PMS_WB_CTRL       4'h8
`define PMS_WB_INFO       4'hC
`define PMS_EV_RD         0
`define PMS_EV_WR         1
`define PMS_EV_LINK       2
`define PMS_EV_SWRST      3

`endif

// ===== shared/pms_pkg.sv
package pms_pkg;
  // frame engine states
  typedef enum logic [2:0] {FS_PRE, FS_ST, FS_HDR, FS_TA, FS_DATA} pms_fstate_t;
  typedef logic [15:0] pms_word_t;
endpackage

// ===== shared/pms_frame_if.sv
`timescale 1ns/100ps
interface pms_frame_if;
  logic            enable;
  logic      [4:0] phy_addr;
  logic            rd_req;
  logic            wr_req;
  logic      [4:0] reg_addr;
  logic     [15:0] wr_data;
  logic     [15:0] rd_data;
  modport engine (input enable, phy_addr, rd_data, output rd_req, wr_req, reg_addr, wr_data);
  modport regs   (output enable, phy_addr, rd_data, input rd_req, wr_req, reg_addr, wr_data);
endinterface

// ===== src/pms_frame_engine.sv
`timescale 1ns/100ps
`include "pms_defs.svh"
module pms_frame_engine import pms_pkg::*; (
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  // management pins, raw
  input  wire logic  mdc_i,
  input  wire logic  mdio_i,
  output logic       mdio_o,
  output logic       mdio_oe,
  // register side
  pms_frame_if.engine fr
);
  logic        mdc_s1_q, mdc_s2_q, mdc_s3_q, mdio_s1_q, mdio_s2_q;
  logic        rise, bit_in, rd_q, oe_q, wr_go_q, rd_go_q;
  logic  [5:0] cnt_q;
  logic [11:0] hdr_q, hdr_d;
  pms_word_t   sh_q;
  pms_fstate_t st_q;

  // ----------------------------------------
  // pin synchronisers, clock edge found in core domain
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {mdc_s1_q, mdc_s2_q, mdc_s3_q, mdio_s1_q, mdio_s2_q} <= 5'h0_0;
    end else begin
      mdc_s1_q  <= mdc_i;
      mdc_s2_q  <= mdc_s1_q;
      mdc_s3_q  <= mdc_s2_q;
      mdio_s1_q <= mdio_i;
      mdio_s2_q <= mdio_s1_q;
    end
  end
  assign rise   = mdc_s2_q & ~mdc_s3_q;
  assign bit_in = mdio_s2_q;
  assign hdr_d  = {hdr_q[10:0], bit_in};

  // ----------------------------------------
  // frame sequencer; the slow link leaves many core cycles per bit
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= FS_PRE;
      cnt_q   <= 6'h0_0;
      hdr_q   <= 12'h000;
      sh_q    <= 16'h0000;
      rd_q    <= 1'b0;
      oe_q    <= 1'b0;
      wr_go_q <= 1'b0;
      rd_go_q <= 1'b0;
    end else begin
      wr_go_q <= 1'b0;
      rd_go_q <= 1'b0;
      if (rise) begin
        unique case (st_q)
          // we only ever listen here; frames start at the controller
          FS_PRE: begin
            if (bit_in) begin
              if (cnt_q != 6'(`PMS_PRE_LEN)) cnt_q <= cnt_q + 6'h0_1;
            end else begin
              if (cnt_q == 6'(`PMS_PRE_LEN)) st_q <= FS_ST;
              cnt_q <= 6'h0_0;
            end
          end
          FS_ST: begin
            st_q  <= bit_in ? FS_HDR : FS_PRE;
            cnt_q <= 6'h0_0;
          end
          FS_HDR: begin
            hdr_q <= hdr_d;
            cnt_q <= cnt_q + 6'h0_1;
            if (cnt_q == 6'h0_B) begin
              cnt_q <= 6'h0_0;
              rd_q  <= (hdr_d[11:10] == `PMS_OP_RD);
              // only our own strapped address is served
              if (fr.enable && hdr_d[9:5] == fr.phy_addr &&
                  (hdr_d[11:10] == `PMS_OP_RD || hdr_d[11:10] == `PMS_OP_WR)) begin
                st_q    <= FS_TA;
                rd_go_q <= (hdr_d[11:10] == `PMS_OP_RD);
              end else begin
                st_q <= FS_PRE;
              end
            end
          end
          FS_TA: begin
            cnt_q <= cnt_q + 6'h0_1;
            if (cnt_q == 6'h0_0 && rd_q) begin
              oe_q <= 1'b1;
              sh_q <= 16'h0000;
            end
            if (cnt_q == 6'h0_1) begin
              cnt_q <= 6'h0_0;
              st_q  <= FS_DATA;
              if (rd_q) sh_q <= fr.rd_data;
            end
          end
          FS_DATA: begin
            cnt_q <= cnt_q + 6'h0_1;
            sh_q  <= rd_q ? {sh_q[14:0], 1'b0} : {sh_q[14:0], bit_in};
            if (cnt_q == 6'h0_F) begin
              oe_q    <= 1'b0;
              wr_go_q <= ~rd_q;
              cnt_q   <= 6'h0_0;
              st_q    <= FS_PRE;
            end
          end
        endcase
      end
    end
  end

  assign mdio_o      = sh_q[15];
  assign mdio_oe     = oe_q;
  assign fr.rd_req   = rd_go_q;
  assign fr.wr_req   = wr_go_q;
  assign fr.reg_addr = hdr_q[4:0];
  assign fr.wr_data  = sh_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [5:0] drv_rises_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) drv_rises_q <= 6'h0_0;
    else if (!oe_q) drv_rises_q <= 6'h0_0;
    else if (rise) drv_rises_q <= drv_rises_q + 6'h0_1;
  end
  chk_drive_read_only: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(mdio_oe) |-> rd_q && $past(st_q) == FS_TA) else $error("line driven outside a read");
  chk_ta_drives_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(mdio_oe) |-> !mdio_o) else $error("turnaround second bit not zero");
  chk_addr_match: assert property (@(posedge core_clk) disable iff (!arst_n)
    (fr.rd_req || fr.wr_req) |-> hdr_q[9:5] == fr.phy_addr) else $error("foreign address served");
  chk_drive_length: assert property (@(posedge core_clk) disable iff (!arst_n)
    drv_rises_q <= 6'd17) else $error("read drive too long");
  chk_write_after_data: assert property (@(posedge core_clk) disable iff (!arst_n)
    fr.wr_req |-> $past(st_q) == FS_DATA && !rd_q) else $error("write without data phase");
  cov_read_frame:  cover property (@(posedge core_clk) disable iff (!arst_n) fr.rd_req);
  cov_write_frame: cover property (@(posedge core_clk) disable iff (!arst_n) fr.wr_req);
endmodule

// ===== src/pms_top.sv
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "pms_defs.svh"
module pms_top import pms_pkg::*; #(
  parameter logic [15:0] ID1_VAL = 16'h1234, // arbitrary identity value
  parameter logic [15:0] ID2_VAL = 16'h5678, // arbitrary identity value
  parameter int          LH_N    = 3
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic  [3:0] wb_adr_i,
  input  wire logic  [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_irq_o,
  // management link
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  // straps and indicator pins
  input  wire logic  [4:0] strap_dev_addr,
  input  wire logic        speed_led_strap_i,
  output logic             speed_led_strap_o,
  output logic             speed_led_strap_oe,
  input  wire logic        duplex_led_strap_i,
  output logic             duplex_led_strap_o,
  output logic             duplex_led_strap_oe,
  // live status from the phy core
  input  wire logic        link_up_in,
  input  wire logic        jabber_in,
  input  wire logic        aneg_done_in,
  input  wire logic        lp_aneg_able_in,
  input  wire logic [15:0] lp_ability_in,
  input  wire logic [LH_N-1:0] lh_event_in,
  // control toward the phy core
  output logic      [15:0] ctrl_o,
  output logic             soft_rst_o,
  output logic             aneg_restart_o,
  output logic             link_change_irq
);
  pms_frame_if fr ();

  logic  [4:0] addr_s1_q, addr_s2_q;
  logic        spd_s1_q, spd_s2_q, dpx_s1_q, dpx_s2_q;
  logic  [1:0] strap_cnt_q;
  logic        strap_done_q, s100_cap_q, fd_cap_q;
  logic        spd_led_q, dpx_led_q;
  pms_word_t   ctrl_q, adv_q, spec_q, rd_q;
  logic  [4:0] sw_cnt_q;
  logic        sw_active, mg_wr, rd_stat, rd_exp;
  logic        link_ll_q, link_prev_q, link_chg;
  logic [LH_N-1:0] lh_q, lh_clr;
  logic        pend_q, queued_q, ack_wr;
  logic  [2:0] gap_q;
  logic        wb_hit, wb_wr, wb_rd;
  logic  [3:0] ev_q, mask_q, ev_set;
  logic        en_q;

  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  pms_frame_engine u_engine (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .mdc_i    (mdc_i),
    .mdio_i   (mdio_i),
    .mdio_o   (mdio_o),
    .mdio_oe  (mdio_oe),
    .fr       (fr.engine)
  );
  assign fr.enable   = en_q;
  assign fr.phy_addr = addr_s2_q;
  assign fr.rd_data  = rd_q;

  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  // address straps are static but still cross into the core domain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {addr_s1_q, addr_s2_q} <= 10'h000;
      {spd_s1_q, spd_s2_q, dpx_s1_q, dpx_s2_q} <= 4'h0;
    end else begin
      addr_s1_q <= strap_dev_addr;
      addr_s2_q <= addr_s1_q;
      spd_s1_q  <= speed_led_strap_i;
      spd_s2_q  <= spd_s1_q;
      dpx_s1_q  <= duplex_led_strap_i;
      dpx_s2_q  <= dpx_s1_q;
    end
  end

  // pins stay inputs until the synchronisers hold real pin levels
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      s100_cap_q   <= 1'b1;
      fd_cap_q     <= 1'b1;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) begin
        s100_cap_q   <= ~spd_s2_q;
        fd_cap_q     <= dpx_s2_q;
        strap_done_q <= 1'b1;
      end
    end
  end

  // indicator outputs once reset is over
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      spd_led_q <= 1'b0;
      dpx_led_q <= 1'b1;
    end else begin
      spd_led_q <= ctrl_q[`PMS_CTRL_SPEED];
      dpx_led_q <= ~ctrl_q[`PMS_CTRL_DUPLEX];
    end
  end
  assign speed_led_strap_o   = spd_led_q;
  assign speed_led_strap_oe  = strap_done_q;
  assign duplex_led_strap_o  = dpx_led_q;
  assign duplex_led_strap_oe = strap_done_q;

  // ----------------------------------------
  // management registers
  // ----------------------------------------
  assign mg_wr     = fr.wr_req;
  assign sw_active = (sw_cnt_q != 5'h0_0);
  assign ack_wr    = mg_wr && fr.reg_addr == `PMS_REG_ACK;

  // partial reset reloads the registers but not the strap capture
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q   <= `PMS_CTRL_DEF;
      adv_q    <= `PMS_ADV_DEF;
      spec_q   <= 16'h0000;
      sw_cnt_q <= 5'h0_0;
    end else begin
      ctrl_q[`PMS_CTRL_ANRST] <= 1'b0;
      if (sw_active) sw_cnt_q <= sw_cnt_q - 5'h0_1;
      if (strap_cnt_q == 2'h2 && !strap_done_q) begin
        adv_q[8:5] <= {~spd_s2_q & dpx_s2_q, ~spd_s2_q, dpx_s2_q, 1'b1};
      end
      if (mg_wr && fr.reg_addr == `PMS_REG_CTRL && fr.wr_data[`PMS_CTRL_RST]) begin
        sw_cnt_q <= 5'(`PMS_SWRST_CYC);
        ctrl_q   <= `PMS_CTRL_DEF;
        adv_q    <= {`PMS_ADV_DEF & 16'hFE1F} |
                    {7'h00, s100_cap_q & fd_cap_q, s100_cap_q, fd_cap_q, 6'h00};
        spec_q   <= 16'h0000;
      end else if (mg_wr && fr.reg_addr == `PMS_REG_CTRL) begin
        ctrl_q <= fr.wr_data & `PMS_CTRL_WMASK;
      end else if (mg_wr && fr.reg_addr == `PMS_REG_ADV) begin
        adv_q <= fr.wr_data & `PMS_ADV_WMASK;
      end else if (mg_wr && fr.reg_addr == `PMS_REG_SPEC) begin
        spec_q <= fr.wr_data;
      end
    end
  end
  assign ctrl_o         = ctrl_q;
  assign soft_rst_o     = sw_active;
  assign aneg_restart_o = ctrl_q[`PMS_CTRL_ANRST];

  // read data is captured when the header ends, long before turnaround
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 16'h0000;
    end else if (fr.rd_req) begin
      unique case (fr.reg_addr)
        `PMS_REG_CTRL: rd_q <= ctrl_q | {sw_active, 15'h0000};
        `PMS_REG_STAT: rd_q <= `PMS_STAT_DEF | {10'h000, aneg_done_in, lh_q[0], 1'b0,
                                                link_ll_q, jabber_in, 1'b0};
        `PMS_REG_ID1:  rd_q <= ID1_VAL;
        `PMS_REG_ID2:  rd_q <= ID2_VAL;
        `PMS_REG_ADV:  rd_q <= adv_q;
        `PMS_REG_LPA:  rd_q <= lp_ability_in;
        `PMS_REG_EXP:  rd_q <= {11'h000, lh_q[1], 2'h0, lh_q[2], lp_aneg_able_in};
        `PMS_REG_SPEC: rd_q <= spec_q;
        default:       rd_q <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // latch-until-read status bits
  // ----------------------------------------
  assign rd_stat = fr.rd_req && fr.reg_addr == `PMS_REG_STAT;
  assign rd_exp  = fr.rd_req && fr.reg_addr == `PMS_REG_EXP;
  assign lh_clr  = {{(LH_N-1){rd_exp}}, rd_stat};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) link_ll_q <= 1'b0;
    else link_ll_q <= rd_stat ? link_up_in : (link_ll_q & link_up_in);
  end

  genvar gi;
  generate
    for (gi = 0; gi < LH_N; gi++) begin : g_lh
      // a read reloads the live level, so an event in that cycle survives
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) lh_q[gi] <= 1'b0;
        else lh_q[gi] <= lh_clr[gi] ? lh_event_in[gi] : (lh_q[gi] | lh_event_in[gi]);
      end
    end
  endgenerate

  // ----------------------------------------
  // link change interrupt, one event may queue behind an acknowledge
  // ----------------------------------------
  assign link_chg = link_up_in ^ link_prev_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_prev_q <= 1'b0;
      pend_q      <= 1'b0;
      queued_q    <= 1'b0;
      gap_q       <= 3'h0;
    end else begin
      link_prev_q <= link_up_in;
      if (ack_wr) begin
        pend_q   <= 1'b0;
        queued_q <= 1'b0;
        if (queued_q || link_chg) gap_q <= 3'(`PMS_IRQ_GAP_CYC);
      end else if (gap_q != 3'h0) begin
        gap_q <= gap_q - 3'h1;
        if (gap_q == 3'h1) pend_q <= 1'b1;
      end else if (link_chg) begin
        if (pend_q) queued_q <= 1'b1;
        else pend_q <= 1'b1;
      end
    end
  end
  // polarity bit clear means active low output
  assign link_change_irq = pend_q ^ ~spec_q[`PMS_SPEC_POL];

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_hit && wb_we_i;
  assign wb_rd  = wb_hit && !wb_we_i;
  assign ev_set = {sw_active & (sw_cnt_q == 5'(`PMS_SWRST_CYC)), link_chg, fr.wr_req, fr.rd_req};

  // one wait state: request taken, ack the edge after
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_rd) begin
        unique case (wb_adr_i)
          `PMS_WB_STATUS: wb_dat_o <= {28'h000_0000, ev_q};
          `PMS_WB_MASK:   wb_dat_o <= {28'h000_0000, mask_q};
          `PMS_WB_CTRL:   wb_dat_o <= {31'h0000_0000, en_q};
          `PMS_WB_INFO:   wb_dat_o <= {22'h00_0000, strap_done_q, fd_cap_q, s100_cap_q,
                                       sw_active, pend_q, addr_s2_q};
          default:        wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sticky events: a set in the clearing read cycle wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_q   <= 4'h0;
      mask_q <= 4'h0;
      en_q   <= 1'b1;
    end else begin
      ev_q <= ((wb_rd && wb_adr_i == `PMS_WB_STATUS) ? 4'h0 : ev_q) | ev_set;
      if (wb_wr && wb_sel_i[0] && wb_adr_i == `PMS_WB_MASK) mask_q <= wb_dat_i[3:0];
      if (wb_wr && wb_sel_i[0] && wb_adr_i == `PMS_WB_CTRL) en_q <= wb_dat_i[0];
    end
  end
  assign wb_irq_o = |(ev_q & mask_q);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_latch_low_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!link_up_in || (!link_ll_q && !rd_stat)) |=> !link_ll_q) else $error("latch-low lost");
  chk_latch_high_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    (lh_q[0] && !rd_stat) |=> lh_q[0]) else $error("latch-high lost");
  chk_irq_ack_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
    ack_wr |=> !pend_q ##1 !pend_q) else $error("interrupt not cleared");
  chk_sc_self_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(sw_active) |-> ##[1:40] !sw_active) else $error("reset bit stuck");
  chk_strap_input: assert property (@(posedge core_clk) disable iff (!arst_n)
    !strap_done_q |-> !speed_led_strap_oe && !duplex_led_strap_oe) else $error("strap driven");
  chk_speed_led: assert property (@(posedge core_clk) disable iff (!arst_n)
    strap_done_q |=> speed_led_strap_o == $past(ctrl_q[`PMS_CTRL_SPEED]))
    else $error("speed indicator wrong");
  chk_wb_ack_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  cov_irq_raised: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(pend_q));
  cov_soft_reset: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(sw_active));
  cov_irq_queued: cover property (@(posedge core_clk) disable iff (!arst_n) ack_wr && queued_q);
endmodule

// ===== bench/pms_mdio_master.sv
`timescale 1ns/100ps
`include "pms_defs.svh"
// ----------------------------------------
// management controller model
// ----------------------------------------
module pms_mdio_master (
  // management pins
  output logic      mdc,
  output logic      mdio_o,
  output logic      mdio_oe,
  input  wire logic mdio_i
);
  // clock stands low between frames, line released
  initial begin
    mdc = 1'b0;
    mdio_o = 1'b1;
    mdio_oe = 1'b0;
  end
  // one whole frame, 160 ns clock, bits change while clock is low
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      mdio_oe = (op == `PMS_OP_WR) || (i > 17);
      mdio_o = bits[i];
      #80 mdc = 1'b1;
      rd = {rd[14:0], mdio_i};
      #80 mdc = 1'b0;
    end
    mdio_oe = 1'b0;
  endtask
endmodule

// ===== bench/phy_mgmt_serial_slave_test.sv
`timescale 1ns/100ps
`include "pms_defs.svh"
// ----------------------------------------
// bench
// ----------------------------------------
module phy_mgmt_serial_slave_test;
  import pms_pkg::*;
  typedef struct {logic [1:0] op; logic [4:0] pa; logic [4:0] ra; pms_word_t wd; pms_word_t ex;}
    pms_row_t;
  logic core_clk, arst_n, cyc, stb, we, lk, dsp_o, dsp_oe, ddx_o, ddx_oe, d_o, d_oe, mdc, m_o, m_oe;
  logic [3:0] adr;
  logic [31:0] dat, q;
  logic [31:0] dat_o;
  logic ack, irq, sr, ir;
  logic [2:0] lh;
  logic [4:0] pa;
  pms_word_t rd;
  int n_errors, checks_done, n;
  wire mline = d_oe ? d_o : (m_oe ? m_o : 1'b1); // pull-up when nobody drives
  wire spd_i = dsp_oe ? dsp_o : 1'b0;
  wire dpx_i = ddx_oe ? ddx_o : 1'b1;
  pms_row_t rows [9] = '{
    '{`PMS_OP_RD, 5'h0B, 5'h02, 16'h0000, 16'h1234}, '{`PMS_OP_RD, 5'h0B, 5'h03, 16'h0000, 16'h5678},
    '{`PMS_OP_RD, 5'h0B, 5'h00, 16'h0000, 16'h3100}, '{`PMS_OP_RD, 5'h0B, 5'h04, 16'h0000, 16'h01E1},
    '{`PMS_OP_WR, 5'h0B, 5'h04, 16'h0061, 16'h0000}, '{`PMS_OP_RD, 5'h0B, 5'h04, 16'h0000, 16'h0061},
    '{`PMS_OP_RD, 5'h0C, 5'h02, 16'h0000, 16'hFFFF}, '{`PMS_OP_WR, 5'h0C, 5'h04, 16'h01E1, 16'h0000},
    '{`PMS_OP_RD, 5'h0B, 5'h04, 16'h0000, 16'h0061}};
  pms_top dut (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_irq_o(irq), .mdc_i(mdc), .mdio_i(mline), .mdio_o(d_o), .mdio_oe(d_oe),
    .strap_dev_addr(pa), .speed_led_strap_i(spd_i), .speed_led_strap_o(dsp_o),
    .speed_led_strap_oe(dsp_oe), .duplex_led_strap_i(dpx_i), .duplex_led_strap_o(ddx_o),
    .duplex_led_strap_oe(ddx_oe), .link_up_in(lk), .jabber_in(1'b0), .aneg_done_in(1'b0),
    .lp_aneg_able_in(1'b0), .lp_ability_in(16'h0000), .lh_event_in(lh), .ctrl_o(),
    .soft_rst_o(sr), .aneg_restart_o(), .link_change_irq(ir));
  pms_mdio_master u_mm (.mdc(mdc), .mdio_o(m_o), .mdio_oe(m_oe), .mdio_i(mline));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) begin
      n_errors++;
      summarize();
    end
    {cyc, stb} <= 2'b00;
  endtask
  task automatic mf(input logic [1:0] op, input logic [4:0] ra, input pms_word_t wd);
    u_mm.frame(op, 5'h0B, ra, wd, rd);
    repeat (10) @(posedge core_clk);
  endtask
  initial begin
    {cyc, stb, we, adr, dat, lk, lh, pa, n_errors, checks_done} = '0;
    pa = 5'h0B;
    arst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("speed pin", {dsp_oe, dsp_o}, 3);
    chk("duplex pin", {ddx_oe, ddx_o}, 2);
    wb(1'b1, `PMS_WB_MASK, 32'h0000_000F);
    foreach (rows[i]) begin
      u_mm.frame(rows[i].op, rows[i].pa, rows[i].ra, rows[i].wd, rd);
      repeat (10) @(posedge core_clk);
      if (rows[i].op == `PMS_OP_RD) chk("frame read", rd, rows[i].ex);
    end
    $display("row tests done");
    chk("irq pending", irq, 1'b1);
    wb(1'b0, `PMS_WB_STATUS, 32'h0);
    chk("status", q, 32'h0000_0003);
    wb(1'b0, `PMS_WB_STATUS, 32'h0);
    chk("status cleared", q, 32'h0);
    chk("irq cleared", irq, 1'b0);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("wishbone tests done");
    @(posedge core_clk) lh <= 3'b001;
    @(posedge core_clk) lh <= 3'b000;
    mf(`PMS_OP_RD, 5'h01, 16'h0);
    chk("latched high", rd[4], 1'b1);
    mf(`PMS_OP_RD, 5'h01, 16'h0);
    chk("released high", rd[4], 1'b0);
    @(posedge core_clk) lk <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("link irq", ir, 1'b0);
    mf(`PMS_OP_WR, 5'h15, 16'hA5A5);
    chk("irq acked", ir, 1'b1);
    mf(`PMS_OP_RD, 5'h01, 16'h0);
    mf(`PMS_OP_RD, 5'h01, 16'h0);
    chk("link live", rd[2], 1'b1);
    @(posedge core_clk) lk <= 1'b0;
    repeat (2) @(posedge core_clk);
    lk <= 1'b1;
    mf(`PMS_OP_RD, 5'h01, 16'h0);
    chk("latched low", rd[2], 1'b0);
    mf(`PMS_OP_RD, 5'h01, 16'h0);
    chk("released low", rd[2], 1'b1);
    $display("latch tests done");
    u_mm.frame(`PMS_OP_WR, 5'h0B, 5'h00, 16'hB100, rd);
    n = 0;
    while (sr !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk("soft reset", sr, 1'b1);
    repeat (40) @(posedge core_clk);
    mf(`PMS_OP_RD, 5'h00, 16'h0);
    chk("self clear", rd, 16'h3100);
    $display("soft reset test done");
    summarize();
  end
endmodule
